/* File: fpl_host_model.sv */
// host model: drives serial clock, select and lanes, samples read data
`timescale 1ns/1ps
module fpl_host_model (
  output logic sck,
  output logic cs_n,
  output logic [3:0] drv,
  output logic [3:0] drv_en,
  input wire logic [3:0] lanes
);
  logic [7:0] rd = 8'h00; // bits sampled on rising edges
  logic [1:0] hw = 2'b11; // hold and protect levels
  initial
  begin
    sck = 1'b0;
    cs_n = 1'b1;
    drv = 4'hC;
    drv_en = 4'hC;
  end
  // select falls with the clock idle low
  task automatic sel;
    #31 cs_n = 1'b0;
    #100;
  endtask
  // select rises to end the frame
  task automatic desel;
    #100 cs_n = 1'b1;
    #100;
  endtask
  // hold and protect pins, changed only with the clock low
  task automatic pins(input logic [1:0] p);
    hw = p;
    drv = {p, drv[1:0]};
  endtask
  // one byte on n lanes, msb first; rx frees the lanes the device drives
  task automatic xfer(input logic [7:0] b, input int n, input logic rx);
    logic [7:0] t;
    logic [3:0] s;
    t = b;
    drv_en = rx ? (n == 4 ? 4'h0 : 4'hC) : (n == 1 ? 4'hD : 4'hF);
    // a leading fall brings out the first bit
    if (rx)
    begin
      #125 sck = 1'b1;
      #75 sck = 1'b0;
    end
    repeat (8 / n)
    begin
      drv = (n == 4) ? t[7:4] : ({hw, 2'b00} | 4'(t >> (8 - n)));
      t = t << n;
      #125 sck = 1'b1;
      s = (n == 1) ? {3'b000, lanes[1]} : (lanes & 4'((1 << n) - 1));
      rd = (rd << n) | {4'h0, s};
      #75 sck = 1'b0;
    end
    drv_en = 4'hC;
    drv = {hw, 2'b00}; // lanes 3-2 back to hold and protect levels
  endtask
endmodule

/* File: fpl_lane_ctrl.sv */
// serial flash pin lane controller: sampling, driving, lane use and hold
// Function
// - capture bits on rising serial clock edges
// - drive output bits on falling serial clock edges
// - dual program takes lanes 1-0 per edge
// - quad program takes lanes 3-0 per edge
// - dual read drives lanes 1-0 per edge
// - quad read drives lanes 3-0 per edge
// - quad lanes only with quad enable set
// - ignore input line while deselected
// - write-protect governs locking when not lane
// - hold ignores clock, data, floats output
// - hold never stops self-timed operations
// - select low starts, high ends operation
// - deselected: output floats, standby after busy
`timescale 1ns/1ps
module fpl_lane_ctrl (
  input wire logic CLK,
  input wire logic RST,
  input wire logic CE,
  input wire logic SCK,
  input wire logic CS_N,
  input wire logic [3:0] IO_IN,
  input wire fpl_pkg::fpl_mode_t MODE,
  input wire logic QUAD_ENABLE,
  input wire logic TX_EN,
  input wire logic [7:0] TX_DATA,
  input wire logic BUSY,
  output logic [3:0] IO_OUT,
  output logic [3:0] IO_OE,
  output logic [7:0] RX_DATA,
  output logic RX_VALID,
  output logic RX_FIRST,
  output logic TX_TAKE,
  output logic WP_LOCK,
  output logic HOLD_ACTIVE,
  output logic STANDBY
);
  // two-stage synchroniser for clock, select and lanes
  logic [fpl_pkg::SYNC_W-1:0] sync1_ff;
  logic [fpl_pkg::SYNC_W-1:0] sync2_ff;
  logic sck_prev_ff; // last synchronised clock level
  logic hold_ff; // hold condition in force
  logic first_ff; // next byte is first of the frame
  logic [fpl_pkg::CNT_W-1:0] rx_cnt_ff; // bits gathered in this byte
  logic [fpl_pkg::BYTE_W-1:0] rx_sr_ff; // input shift register
  logic [fpl_pkg::CNT_W-1:0] tx_cnt_ff; // bits sent of this byte
  logic [fpl_pkg::BYTE_W-1:0] tx_sr_ff; // output shift register
  logic wp_lock_ff;
  logic standby_ff;
  logic rx_valid_ff;
  logic rx_first_ff;
  logic tx_take_ff;
  logic [7:0] rx_data_ff;
  logic [3:0] io_out_ff;
  logic [3:0] io_oe_ff;
  // synchronised views
  logic sck_s;
  logic cs_n_s;
  logic [3:0] io_s;
  logic rise;
  logic fall;
  logic active; // selected and not held
  fpl_pkg::fpl_mode_t eff_mode; // mode after quad gating
  logic quad_lanes; // lanes 2 and 3 carry data
  logic out_mode; // lanes 1-0 are outputs in dual or quad read
  logic hold_req; // hold pin asserted as a control
  logic [3:0] bpe; // bits per edge
  logic [3:0] rx_sum;
  logic [fpl_pkg::BYTE_W-1:0] nxt_rx_sr;
  logic [fpl_pkg::BYTE_W-1:0] tx_word;
  logic [fpl_pkg::BYTE_W-1:0] nxt_tx_sr;
  logic [3:0] nxt_io_out;
  logic [3:0] nxt_io_oe;
  assign sck_s = sync2_ff[fpl_pkg::SYNC_SCK];
  assign cs_n_s = sync2_ff[fpl_pkg::SYNC_CS];
  assign io_s = sync2_ff[3:0];
  assign rise = sck_s & ~sck_prev_ff;
  assign fall = ~sck_s & sck_prev_ff;
  assign active = ~cs_n_s & ~hold_ff;
  assign rx_sum = {1'b0, rx_cnt_ff} + bpe;
  // pin synchroniser, first stage read only by the second
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      sync1_ff <= fpl_pkg::SYNC_RST; // idle pin levels, no false hold
      sync2_ff <= fpl_pkg::SYNC_RST;
      sck_prev_ff <= 1'b0;
    end
    else if (CE)
    begin
      sync1_ff <= {SCK, CS_N, IO_IN};
      sync2_ff <= sync1_ff;
      sck_prev_ff <= sck_s;
    end
  end
  // quad modes fall back to single lane without quad enable
  always_comb
  begin
    eff_mode = MODE;
    if ((MODE == fpl_pkg::FPL_QUAD_IN || MODE == fpl_pkg::FPL_QUAD_OUT) && !QUAD_ENABLE)
    begin
      eff_mode = fpl_pkg::FPL_SINGLE;
    end
    quad_lanes = (eff_mode == fpl_pkg::FPL_QUAD_IN) || (eff_mode == fpl_pkg::FPL_QUAD_OUT);
    out_mode = TX_EN && (eff_mode == fpl_pkg::FPL_DUAL_OUT || eff_mode == fpl_pkg::FPL_QUAD_OUT);
    hold_req = ~io_s[fpl_pkg::LANE_HOLD] & ~quad_lanes;
  end
  // lane width and input shift per mode
  always_comb
  begin
    case (eff_mode)
      fpl_pkg::FPL_QUAD_IN, fpl_pkg::FPL_QUAD_OUT:
      begin
        bpe = fpl_pkg::BPE_QUAD;
        nxt_rx_sr = {rx_sr_ff[3:0], io_s};
      end
      fpl_pkg::FPL_DUAL_IN, fpl_pkg::FPL_DUAL_OUT:
      begin
        bpe = fpl_pkg::BPE_DUAL;
        nxt_rx_sr = {rx_sr_ff[5:0], io_s[1:0]};
      end
      default:
      begin
        bpe = fpl_pkg::BPE_SINGLE;
        nxt_rx_sr = {rx_sr_ff[6:0], io_s[fpl_pkg::LANE_SI]};
      end
    endcase
  end
  // output word, next shift and lane drive per mode
  always_comb
  begin
    tx_word = (tx_cnt_ff == '0) ? TX_DATA : tx_sr_ff;
    nxt_io_oe = fpl_pkg::OE_NONE;
    case (eff_mode)
      fpl_pkg::FPL_QUAD_OUT:
      begin
        nxt_io_out = tx_word[7:4];
        nxt_tx_sr = {tx_word[3:0], 4'h0};
        nxt_io_oe = fpl_pkg::OE_QUAD;
      end
      fpl_pkg::FPL_DUAL_OUT:
      begin
        nxt_io_out = {2'h0, tx_word[7:6]};
        nxt_tx_sr = {tx_word[5:0], 2'h0};
        nxt_io_oe = fpl_pkg::OE_DUAL;
      end
      fpl_pkg::FPL_SINGLE:
      begin
        nxt_io_out = {2'h0, tx_word[7], 1'b0};
        nxt_tx_sr = {tx_word[6:0], 1'b0};
        nxt_io_oe = fpl_pkg::OE_SINGLE;
      end
      default:
      begin
        nxt_io_out = 4'h0; // program modes never drive
        nxt_tx_sr = tx_word;
      end
    endcase
    if (!active || !TX_EN)
    begin
      nxt_io_oe = fpl_pkg::OE_NONE;
    end
  end
  // hold starts with select low and clock low, ends on release
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      hold_ff <= 1'b0;
    end
    else if (CE)
    begin
      if (cs_n_s || (hold_ff && !hold_req))
      begin
        hold_ff <= 1'b0; // deselect or pin released
      end
      else if (!hold_ff && hold_req && !sck_s)
      begin
        hold_ff <= 1'b1;
      end
    end
  end
  // input capture on rising edges while selected
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      rx_cnt_ff <= '0;
      rx_sr_ff <= '0;
      first_ff <= 1'b1;
      rx_valid_ff <= 1'b0;
      rx_first_ff <= 1'b0;
      rx_data_ff <= '0;
    end
    else if (CE)
    begin
      rx_valid_ff <= 1'b0;
      if (cs_n_s)
      begin
        rx_cnt_ff <= '0;
        first_ff <= 1'b1;
      end
      else if (active && rise && !out_mode)
      begin
        rx_sr_ff <= nxt_rx_sr;
        rx_cnt_ff <= rx_sum[fpl_pkg::CNT_W-1:0];
        if (rx_sum == fpl_pkg::BYTE_BITS)
        begin
          rx_valid_ff <= 1'b1;
          rx_data_ff <= nxt_rx_sr;
          rx_first_ff <= first_ff;
          first_ff <= 1'b0;
        end
      end
    end
  end
  // output drive on falling edges in output phases
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      tx_cnt_ff <= '0;
      tx_sr_ff <= '0;
      tx_take_ff <= 1'b0;
      io_out_ff <= '0;
    end
    else if (CE)
    begin
      tx_take_ff <= 1'b0;
      if (cs_n_s || !TX_EN)
      begin
        tx_cnt_ff <= '0;
      end
      else if (active && fall)
      begin
        io_out_ff <= nxt_io_out;
        tx_sr_ff <= nxt_tx_sr;
        tx_cnt_ff <= tx_cnt_ff + bpe[fpl_pkg::CNT_W-1:0];
        tx_take_ff <= (tx_cnt_ff == '0);
      end
    end
  end
  // output enables follow select, hold and output phase
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      io_oe_ff <= '0;
    end
    else if (CE)
    begin
      io_oe_ff <= nxt_io_oe;
    end
  end
  // write-protect locking, kept while the pin carries quad data
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      wp_lock_ff <= 1'b0;
    end
    else if (CE && !quad_lanes)
    begin
      wp_lock_ff <= ~io_s[fpl_pkg::LANE_WP];
    end
  end
  // standby only once deselected and self-timed work is done
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      standby_ff <= 1'b0;
    end
    else if (CE)
    begin
      standby_ff <= cs_n_s && !BUSY;
    end
  end
  assign IO_OUT = io_out_ff;
  assign IO_OE = io_oe_ff;
  assign RX_DATA = rx_data_ff;
  assign RX_VALID = rx_valid_ff;
  assign RX_FIRST = rx_first_ff;
  assign TX_TAKE = tx_take_ff;
  assign WP_LOCK = wp_lock_ff;
  assign HOLD_ACTIVE = hold_ff;
  assign STANDBY = standby_ff;
  // checks, lanes, select and hold
  property p_rx_on_rise;
    @(posedge CLK) disable iff (RST) RX_VALID |-> $past(rise) && !$past(hold_ff);
  endproperty
  a_rx_on_rise: assert property (p_rx_on_rise) else $error("byte done off a rising edge");
  property p_tx_on_fall;
    @(posedge CLK) disable iff (RST) TX_TAKE |-> $past(fall) && $past(TX_EN);
  endproperty
  a_tx_on_fall: assert property (p_tx_on_fall) else $error("output loaded off a falling edge");
  property p_no_rx_deselected;
    @(posedge CLK) disable iff (RST) RX_VALID |-> !$past(cs_n_s);
  endproperty
  a_no_rx_deselected: assert property (p_no_rx_deselected) else $error("data taken deselected");
  property p_deselect_float;
    @(posedge CLK) disable iff (RST) (CE && cs_n_s) |=> IO_OE == fpl_pkg::OE_NONE;
  endproperty
  a_deselect_float: assert property (p_deselect_float) else $error("lane driven deselected");
  property p_hold_float;
    @(posedge CLK) disable iff (RST) (CE && hold_ff) |=> IO_OE == fpl_pkg::OE_NONE;
  endproperty
  a_hold_float: assert property (p_hold_float) else $error("lane driven during hold");
  property p_quad_needs_qe;
    @(posedge CLK) disable iff (RST) (CE && !QUAD_ENABLE) |=> IO_OE[3:2] == 2'h0;
  endproperty
  a_quad_needs_qe: assert property (p_quad_needs_qe) else $error("quad lanes without enable");
  property p_quad_out_oe;
    @(posedge CLK) disable iff (RST)
      (CE && active && TX_EN && eff_mode == fpl_pkg::FPL_QUAD_OUT) |=> IO_OE == fpl_pkg::OE_QUAD;
  endproperty
  a_quad_out_oe: assert property (p_quad_out_oe) else $error("quad read lanes not driven");
  property p_dual_out_oe;
    @(posedge CLK) disable iff (RST)
      (CE && active && TX_EN && eff_mode == fpl_pkg::FPL_DUAL_OUT) |=> IO_OE == fpl_pkg::OE_DUAL;
  endproperty
  a_dual_out_oe: assert property (p_dual_out_oe) else $error("dual read lanes wrong");
  property p_standby_waits;
    @(posedge CLK) disable iff (RST) (CE && BUSY) |=> !STANDBY;
  endproperty
  a_standby_waits: assert property (p_standby_waits) else $error("standby while busy");
  property p_quad_no_hold;
    @(posedge CLK) disable iff (RST) (CE && quad_lanes) |=> !hold_ff;
  endproperty
  a_quad_no_hold: assert property (p_quad_no_hold) else $error("hold taken from quad lane");
  property p_wp_lock;
    @(posedge CLK) disable iff (RST)
      (CE && !quad_lanes) |=> WP_LOCK == !$past(io_s[fpl_pkg::LANE_WP]);
  endproperty
  a_wp_lock: assert property (p_wp_lock) else $error("lock does not follow protect pin");
endmodule

/* File: fpl_lane_ctrl_tb_top.sv */
// self-checking bench for the serial flash pin lane controller
`timescale 1ns/1ps
`define CHK(a, b) \
  begin \
    num_checks++; \
    if ((a) !== (b)) \
    begin \
      fail_count++; \
      $display("MISMATCH %0t got %h want %h", $time, (a), (b)); \
    end \
  end
module fpl_lane_ctrl_tb_top;
  logic clk = 1'b0;
  logic rst = 1'b1;
  fpl_pkg::fpl_mode_t mode = fpl_pkg::FPL_SINGLE; // lane use
  logic qe = 1'b0;
  logic tx_en = 1'b0;
  logic [7:0] tx_data = 8'h00;
  logic busy = 1'b0;
  logic ce = 1'b1; // clock enable of the device
  logic flt = 1'b0; // changing level on released lanes 1-0
  logic sck, cs_n, rx_valid, rx_first, rx_fst, wp_lock, hold_active, standby, tx_take;
  logic [3:0] h_drv, h_en, io_out, io_oe;
  wire logic [3:0] lanes;
  logic [7:0] rx_data, rx_byte;
  int rx_n = 0;
  int tk_n = 0; // bytes taken for sending
  int fail_count = 0;
  int num_checks = 0;
  always #12.5 clk = ~clk;
  always @(posedge clk) flt <= ~flt;
  // wire levels: device first, then host, else pull-ups on lanes 3-2
  assign lanes = (io_oe & io_out) | (~io_oe & h_en & h_drv)
    | (~io_oe & ~h_en & {2'b11, flt, flt});
  // record each received byte and each byte taken for sending
  always @(posedge clk)
  begin
    if (rx_valid === 1'b1)
    begin
      rx_n++;
      rx_byte = rx_data;
      rx_fst = rx_first;
    end
    if (tx_take === 1'b1)
    begin
      tk_n++;
    end
  end
  fpl_lane_ctrl u_dut (.CLK(clk), .RST(rst), .CE(ce), .SCK(sck), .CS_N(cs_n),
    .IO_IN(lanes), .MODE(mode), .QUAD_ENABLE(qe), .TX_EN(tx_en), .TX_DATA(tx_data),
    .BUSY(busy), .IO_OUT(io_out), .IO_OE(io_oe), .RX_DATA(rx_data),
    .RX_VALID(rx_valid), .RX_FIRST(rx_first), .TX_TAKE(tx_take), .WP_LOCK(wp_lock),
    .HOLD_ACTIVE(hold_active), .STANDBY(standby));
  fpl_host_model u_host (.sck(sck), .cs_n(cs_n), .drv(h_drv), .drv_en(h_en),
    .lanes(lanes));
  task automatic wclk(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic setm(input fpl_pkg::fpl_mode_t m, input logic q, input logic t,
    input logic [7:0] d);
    wclk(1);
    mode = m;
    qe = q;
    tx_en = t;
    tx_data = d;
  endtask
  // two program bytes in one frame in lane use m
  task automatic prog1(input fpl_pkg::fpl_mode_t m, input logic q, input int n,
    input logic [7:0] b);
    int n0;
    n0 = rx_n;
    setm(m, q, 1'b0, 8'h00);
    u_host.sel();
    u_host.xfer(b, n, 1'b0);
    wclk(6);
    `CHK(rx_n, n0 + 1)
    `CHK(rx_byte, b)
    `CHK(rx_fst, 1'b1)
    u_host.xfer(~b, n, 1'b0);
    wclk(6);
    `CHK(rx_n, n0 + 2)
    `CHK(rx_byte, ~b)
    `CHK(rx_fst, 1'b0)
    u_host.desel();
  endtask
  // one read byte in lane use m
  task automatic read1(input fpl_pkg::fpl_mode_t m, input logic q, input int n,
    input logic [3:0] oe, input logic [7:0] b);
    int t0;
    t0 = tk_n;
    setm(m, q, 1'b1, b);
    u_host.sel();
    wclk(4);
    `CHK(io_oe, oe)
    u_host.xfer(8'h00, n, 1'b1);
    `CHK(u_host.rd, b)
    wclk(6);
    `CHK(tk_n, t0 + 2)
    u_host.desel();
    wclk(4);
    `CHK(io_oe, fpl_pkg::OE_NONE)
  endtask
  task automatic t_program;
    prog1(fpl_pkg::FPL_SINGLE, 1'b0, 1, 8'hA5);
    prog1(fpl_pkg::FPL_DUAL_IN, 1'b0, 2, 8'h3C);
    prog1(fpl_pkg::FPL_QUAD_IN, 1'b1, 4, 8'h96);
    prog1(fpl_pkg::FPL_QUAD_IN, 1'b0, 1, 8'hC3);
  endtask
  task automatic t_read;
    read1(fpl_pkg::FPL_SINGLE, 1'b0, 1, fpl_pkg::OE_SINGLE, 8'h5A);
    read1(fpl_pkg::FPL_DUAL_OUT, 1'b0, 2, fpl_pkg::OE_DUAL, 8'h69);
    read1(fpl_pkg::FPL_QUAD_OUT, 1'b1, 4, fpl_pkg::OE_QUAD, 8'hB4);
  endtask
  // clocking with select high while a cycle is busy
  task automatic t_desel;
    int n0;
    n0 = rx_n;
    setm(fpl_pkg::FPL_SINGLE, 1'b0, 1'b0, 8'h00);
    busy = 1'b1;
    u_host.xfer(8'hFF, 1, 1'b0);
    wclk(6);
    `CHK(rx_n, n0)
    `CHK(standby, 1'b0)
    busy = 1'b0;
    wclk(3);
    `CHK(standby, 1'b1)
  endtask
  // clock enable low freezes the standby flag
  task automatic t_freeze;
    ce = 1'b0;
    busy = 1'b1;
    wclk(4);
    `CHK(standby, 1'b1)
    ce = 1'b1;
    wclk(3);
    `CHK(standby, 1'b0)
    busy = 1'b0;
  endtask
  // pause at the start of a read, clock ignored, then protect pin low
  task automatic t_hold;
    int n0;
    setm(fpl_pkg::FPL_SINGLE, 1'b0, 1'b1, 8'hA5);
    busy = 1'b1;
    u_host.sel();
    u_host.pins(2'b01);
    wclk(6);
    `CHK(hold_active, 1'b1)
    `CHK(io_oe, fpl_pkg::OE_NONE)
    n0 = rx_n;
    u_host.xfer(8'h00, 1, 1'b0);
    wclk(6);
    `CHK(rx_n, n0)
    `CHK(standby, 1'b0)
    u_host.pins(2'b10);
    wclk(6);
    `CHK(hold_active, 1'b0)
    `CHK(io_oe, fpl_pkg::OE_SINGLE)
    `CHK(wp_lock, 1'b1)
    u_host.desel();
    u_host.pins(2'b11);
    wclk(1);
    busy = 1'b0;
  endtask
  task automatic conclude;
    if (fail_count == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial
  begin
    wclk(6);
    rst = 1'b0;
    wclk(4);
    t_program;
    t_read;
    t_desel;
    t_freeze;
    t_hold;
    conclude();
  end
  // watchdog well past the expected run
  initial
  begin
    #300000;
    fail_count++;
    conclude();
  end
endmodule

/* File: fpl_pkg.sv */
// constants and types for the serial flash pin lane controller
package fpl_pkg;
  // lane positions on the data lanes
  localparam int LANE_SI = 0;
  localparam int LANE_SO = 1;
  localparam int LANE_WP = 2;
  localparam int LANE_HOLD = 3;
  // widths
  localparam int LANES = 4;
  localparam int BYTE_W = 8;
  localparam int CNT_W = 3;
  localparam int SYNC_W = 6;
  // positions inside the synchroniser vector
  localparam int SYNC_SCK = 5;
  localparam int SYNC_CS = 4;
  // synchroniser reset: clock low, select high, protect and hold high
  localparam logic [SYNC_W-1:0] SYNC_RST = 6'h1C;
  // bits moved per serial clock edge
  localparam logic [3:0] BPE_SINGLE = 4'h1;
  localparam logic [3:0] BPE_DUAL = 4'h2;
  localparam logic [3:0] BPE_QUAD = 4'h4;
  // bit count of a whole byte
  localparam logic [3:0] BYTE_BITS = 4'h8;
  // output enable patterns per lane use
  localparam logic [3:0] OE_NONE = 4'h0;
  localparam logic [3:0] OE_SINGLE = 4'h2;
  localparam logic [3:0] OE_DUAL = 4'h3;
  localparam logic [3:0] OE_QUAD = 4'hF;
  // lane use requested by the command decoder
  typedef enum logic [2:0] {
    FPL_SINGLE,
    FPL_DUAL_IN,
    FPL_QUAD_IN,
    FPL_DUAL_OUT,
    FPL_QUAD_OUT
  } fpl_mode_t;
endpackage
